// ==== pkg/sar_map.svh ====
// Named widths and reset values for the conversion sequencer.
// Assumes inclusion by bare name from files that need the figures.
`ifndef SAR_MAP_SVH
`define SAR_MAP_SVH

// Result width and trial index width
`define SAR_BITS 12
`define SAR_IDX_W 4
// Upper nibble of result, and the zero nibble driven in byte mode
`define SAR_HI_LSB 8
`define SAR_NIB_ZERO 4'h0
`define SAR_NIB_W 4
// Reset image of synchroniser: {clk, cs_n, rd_n, hbe, cmp}
`define SAR_SYNC_W 5
`define SAR_SYNC_RST 5'h0e
// Positions of the pins inside the synchroniser word
`define SAR_POS_CLK 4
`define SAR_POS_CS 3
`define SAR_POS_RD 2
`define SAR_POS_HBE 1
`define SAR_POS_KEEP 0

`endif

// ==== pkg/sar_pkg.sv ====
// Types shared by the conversion sequencer.
// Assumes nothing beyond a SystemVerilog compiler.
package sar_pkg;

    // One-hot sequencer states
    typedef enum logic [3:0] {
        ST_SAMPLE = 4'h1,
        ST_WAIT = 4'h2,
        ST_DECIDE = 4'h4,
        ST_LATCH = 4'h8
    } state_t;

endpackage : sar_pkg

// ==== core/sar_bit_trial.sv ====
// Bit-trial register of the successive-approximation loop.
// Assumes clear, arm and decide are one-cycle pulses from the sequencer, never together.
`timescale 1ns/1ps
`include "sar_map.svh"

module sar_bit_trial #(
    parameter int BITS = `SAR_BITS,
    parameter int IW = `SAR_IDX_W
) (
    input wire logic clock, // System clock
    input wire logic rst_n, // Synchronised reset, active low
    input wire logic clear, // Start of conversion
    input wire logic arm, // Set the top trial bit
    input wire logic decide, // Resolve bit at idx
    input wire logic [IW-1:0] idx, // Bit under decision
    input wire logic keep, // Comparator says keep the bit
    output logic [BITS-1:0] trial_code // Natural binary trial word, bit BITS-1 is MSB
);

    ////////////////////////////////////////////////////////////////////////
    // One flop per bit: decided bit takes keep, next lower bit is tried
    genvar i;
    generate
        for (i = 0; i < BITS; i++)
        begin : g_bit
            localparam logic [IW-1:0] MY_IDX = IW'(i);
            localparam logic [IW-1:0] UP_IDX = IW'(i + 1);
            wire logic do_decide = decide && (idx == MY_IDX);
            wire logic do_try = (arm && (i == BITS - 1)) || (decide && (idx == UP_IDX));

            // Trial bit update
            always_ff @(posedge clock or negedge rst_n)
            begin
                if (!rst_n)
                    trial_code[i] <= 1'b0;
                else if (clear)
                    trial_code[i] <= 1'b0;
                else if (do_decide)
                    trial_code[i] <= keep;
                else if (do_try)
                    trial_code[i] <= 1'b1;
            end
        end
    endgenerate

endmodule : sar_bit_trial

// ==== core/sar_adc_conversion_sequencer.sv ====
// Conversion sequencer of a 12-bit successive-approximation converter.
// Assumes all pins (converter clock, selects, read, comparator) are asynchronous to clock.
`timescale 1ns/1ps
`include "sar_map.svh"

// Contract
// - Conversion starts only from device select, read strobe and upper-byte select.
// - At start, clear the bit-trial register and enable the data drivers.
// - Further start conditions are ignored until the running conversion ends.
// - Twelve bits are tested MSB first down to LSB by comparator decision.
// - Sampling phase from conversion end until next start, then convert phase.
// - MSB decision happens on the second falling converter clock edge after start.
// - Each later bit is decided on the following falling converter clock edge.
// - At conversion end the trial word is copied into the 12-bit output latch.
// - Conversion works whatever the start phase relative to the converter clock.
// - Clock output is the inverse of the converter clock input.
// - External converter clock duty cycle does not matter.
// - Results are unsigned natural binary, one step is full scale over 4096.
// - Code transitions sit at half steps; the analog comparator provides this.
// - Result bits numbered eleven down to zero, eleven is the MSB.
// - Busy output low during a conversion, high otherwise.
// - Start needs read, select and upper-byte select all low; high byte select blocks.
// - Byte select low gives 12 bits in place; high copies top nibble low, keeps it on top, zeros middle.
module sar_adc_conversion_sequencer #(
    parameter int BITS = `SAR_BITS,
    parameter int IW = `SAR_IDX_W
) (
    input wire logic clock, // 125 MHz system clock
    input wire logic rst_n, // Asynchronous reset, active low
    input wire logic conv_clk_in, // Converter clock pin
    input wire logic cs_n, // Device select, active low
    input wire logic rd_n, // Read strobe, active low
    input wire logic upper_byte_select, // High byte select, blocks starts when high
    input wire logic cmp_keep, // Comparator: keep the bit under trial
    output logic clk_out, // Inverted converter clock
    output logic busy_n, // Low while converting
    output logic sample_phase, // High while the input is sampled
    output logic [BITS-1:0] trial_code, // Trial word to the DAC
    output logic [BITS-1:0] output_pins, // Three-state data outputs
    output logic [BITS-1:0] output_oe // Output enables, high drives
);

    ////////////////////////////////////////////////////////////////////////
    // Reset release through two flops
    logic rst_s1_r;
    logic rst_s2_r;
    wire logic rst_sync_n = rst_s2_r;

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_s1_r <= 1'b0;
            rst_s2_r <= 1'b0;
        end
        else
        begin
            rst_s1_r <= 1'b1;
            rst_s2_r <= rst_s1_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers, plus a third clock stage for edge detection
    logic [`SAR_SYNC_W-1:0] sync1_r;
    logic [`SAR_SYNC_W-1:0] sync2_r;
    logic clk_s3_r;
    wire logic [`SAR_SYNC_W-1:0] pins_raw = {conv_clk_in, cs_n, rd_n, upper_byte_select, cmp_keep};

    always_ff @(posedge clock or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            sync1_r <= `SAR_SYNC_RST;
            sync2_r <= `SAR_SYNC_RST;
            clk_s3_r <= 1'b0;
        end
        else
        begin
            sync1_r <= pins_raw;
            sync2_r <= sync1_r;
            clk_s3_r <= sync2_r[`SAR_POS_CLK];
        end
    end

    // Synchronised pin levels
    wire logic clk_s = sync2_r[`SAR_POS_CLK];
    wire logic cs_s_n = sync2_r[`SAR_POS_CS];
    wire logic rd_s_n = sync2_r[`SAR_POS_RD];
    wire logic hbe_s = sync2_r[`SAR_POS_HBE];
    wire logic keep_s = sync2_r[`SAR_POS_KEEP];

    ////////////////////////////////////////////////////////////////////////
    // Start and edge decode
    logic start_cond_r;
    sar_pkg::state_t state_r;
    sar_pkg::state_t state_nxt;
    logic [IW-1:0] bit_idx_r;
    logic [IW-1:0] bit_idx_nxt;
    logic [BITS-1:0] result_r;

    wire logic start_cond = ~cs_s_n & ~rd_s_n & ~hbe_s;
    wire logic idle = (state_r == sar_pkg::ST_SAMPLE);
    wire logic start_evt = start_cond & ~start_cond_r & idle;
    wire logic clk_fall = clk_s3_r & ~clk_s;
    wire logic trial_arm = (state_r == sar_pkg::ST_WAIT) & clk_fall;
    wire logic trial_decide = (state_r == sar_pkg::ST_DECIDE) & clk_fall;
    wire logic drive_en = ~cs_s_n & ~rd_s_n;
    wire logic [BITS-1:0] byte_view = {result_r[BITS-1:`SAR_HI_LSB], `SAR_NIB_ZERO, result_r[BITS-1:`SAR_HI_LSB]};
    wire logic [BITS-1:0] pins_nxt = hbe_s ? byte_view : result_r;

    // Sequencer next state
    always_comb
    begin
        state_nxt = state_r;
        bit_idx_nxt = bit_idx_r;
        unique case (state_r)
            sar_pkg::ST_SAMPLE:
                if (start_evt)
                    state_nxt = sar_pkg::ST_WAIT;
            sar_pkg::ST_WAIT:
                if (clk_fall)
                begin
                    state_nxt = sar_pkg::ST_DECIDE;
                    bit_idx_nxt = IW'(BITS - 1);
                end
            sar_pkg::ST_DECIDE:
                if (clk_fall)
                begin
                    if (bit_idx_r == '0)
                        state_nxt = sar_pkg::ST_LATCH;
                    else
                        bit_idx_nxt = bit_idx_r - 1'b1;
                end
            sar_pkg::ST_LATCH:
                state_nxt = sar_pkg::ST_SAMPLE;
            default:
                state_nxt = sar_pkg::ST_SAMPLE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer and output flops
    always_ff @(posedge clock or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            state_r <= sar_pkg::ST_SAMPLE;
            bit_idx_r <= '0;
            start_cond_r <= 1'b0;
            result_r <= '0;
            busy_n <= 1'b1;
            sample_phase <= 1'b1;
            clk_out <= 1'b1;
            output_pins <= '0;
            output_oe <= '0;
        end
        else
        begin
            state_r <= state_nxt;
            bit_idx_r <= bit_idx_nxt;
            start_cond_r <= start_cond;
            if (state_r == sar_pkg::ST_LATCH)
                result_r <= trial_code;
            busy_n <= (state_nxt == sar_pkg::ST_SAMPLE);
            sample_phase <= (state_nxt == sar_pkg::ST_SAMPLE);
            clk_out <= ~clk_s;
            output_pins <= pins_nxt;
            output_oe <= {BITS{drive_en}};
        end
    end

    // Bit-trial register
    sar_bit_trial #(.BITS(BITS), .IW(IW)) u_trial (
        .clock(clock),
        .rst_n(rst_sync_n),
        .clear(start_evt),
        .arm(trial_arm),
        .decide(trial_decide),
        .idx(bit_idx_r),
        .keep(keep_s),
        .trial_code(trial_code)
    );

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_sync_n);

    sequence s_start;
        start_evt;
    endsequence

    sequence s_wait_first_fall;
        (state_r == sar_pkg::ST_WAIT) [*1] ##0 !trial_decide;
    endsequence

    property p_start_cause;
        $fell(busy_n) |-> $past(start_cond) && !$past(start_cond, 2);
    endproperty
    a_start_cause: assert property (p_start_cause) else $error("conversion began without a start");

    property p_clear;
        s_start |=> (trial_code == '0) and s_wait_first_fall;
    endproperty
    a_clear: assert property (p_clear) else $error("trial word not cleared at start");

    property p_no_restart;
        (state_r == sar_pkg::ST_DECIDE && start_cond && !start_cond_r) |=>
            !idle && ($stable(bit_idx_r) || $past(clk_fall));
    endproperty
    a_no_restart: assert property (p_no_restart) else $error("active conversion restarted");

    property p_order;
        (trial_decide && bit_idx_r != '0) |=> bit_idx_r == $past(bit_idx_r) - 1'b1;
    endproperty
    a_order: assert property (p_order) else $error("bit order broken");

    property p_msb_arm;
        trial_arm |=> trial_code[BITS-1] && state_r == sar_pkg::ST_DECIDE && bit_idx_r == IW'(BITS - 1);
    endproperty
    a_msb_arm: assert property (p_msb_arm) else $error("MSB not tried after first fall");

    property p_busy;
        (state_r == sar_pkg::ST_SAMPLE) == busy_n && busy_n == sample_phase;
    endproperty
    a_busy: assert property (p_busy) else $error("busy disagrees with sequencer");

    property p_clk_out;
        clk_out == !clk_s3_r;
    endproperty
    a_clk_out: assert property (p_clk_out) else $error("clock output not inverted input");

    property p_latch;
        (state_r == sar_pkg::ST_LATCH) |=> result_r == $past(trial_code) && busy_n;
    endproperty
    a_latch: assert property (p_latch) else $error("result not latched at end");

    property p_byte_mux;
        hbe_s |=> output_pins[`SAR_HI_LSB-1:`SAR_NIB_W] == `SAR_NIB_ZERO &&
            output_pins[`SAR_NIB_W-1:0] == output_pins[BITS-1:`SAR_HI_LSB];
    endproperty
    a_byte_mux: assert property (p_byte_mux) else $error("byte view wrong");

    property p_oe;
        !drive_en |=> output_oe == '0;
    endproperty
    a_oe: assert property (p_oe) else $error("outputs driven without read");

endmodule : sar_adc_conversion_sequencer

// ==== test/sar_host_model.sv ====
// Bus host model: drives device select, read strobe and byte select.
// Assumes one bench process calls its tasks, never two at once.
`timescale 1ns/1ps

module sar_host_model (
    input wire logic clock, // System clock
    output logic cs_n, // Device select, active low
    output logic rd_n, // Read strobe, active low
    output logic upper_byte_select // High byte select
);
    ////////////////////////////////////////////////////////////////
    // Bus idle at time zero
    initial
    begin
        cs_n = 1'b1;
        rd_n = 1'b1;
        upper_byte_select = 1'b1;
    end

    // Read cycle: strobe low, select and byte select as given, just after an edge, then held
    task automatic strobe(input logic hbe, input logic sel_n);
        @(posedge clock);
        #1;
        upper_byte_select = hbe;
        cs_n = sel_n;
        rd_n = 1'b0; // start phase left free, clock distance only helps analog noise
    endtask : strobe

    // Release the bus and stay idle, long enough for acquisition
    task automatic release_bus(input int gap);
        @(posedge clock);
        #1;
        cs_n = 1'b1;
        rd_n = 1'b1;
        repeat (gap) @(posedge clock);
    endtask : release_bus
endmodule : sar_host_model

// ==== test/tb.sv ====
// Self-checking bench of the conversion sequencer.
// Assumes the host model above and a behavioural comparator.
`timescale 1ns/1ps

module tb;
    logic clock;
    logic rst_n;
    logic conv_clk_in;
    logic cmp_keep;
    logic cs_n, rd_n, upper_byte_select;
    logic clk_out, busy_n, sample_phase, last_cc;
    logic [11:0] trial_code, output_pins, output_oe, target;
    logic [31:0] lfsr_r;
    logic [11:0] exp_q[$];
    int failures, checked, lowc, pend, stable;
    bit rst_done, timed_out;

    ////////////////////////////////////////////////////////////////
    // Clocks: system clock and an uneven converter clock, period 13 system clock periods
    always #4 clock = ~clock;
    always
    begin
        #41 conv_clk_in = 1'b1;
        #63 conv_clk_in = 1'b0;
    end

    // Comparator keeps a bit while the trial word is not above the input
    assign #1 cmp_keep = (trial_code <= target);

    sar_host_model sar_host_model_i (.clock(clock), .cs_n(cs_n), .rd_n(rd_n),
        .upper_byte_select(upper_byte_select));
    sar_adc_conversion_sequencer sar_adc_conversion_sequencer_i (.clock(clock), .rst_n(rst_n),
        .conv_clk_in(conv_clk_in), .cs_n(cs_n), .rd_n(rd_n), .upper_byte_select(upper_byte_select),
        .cmp_keep(cmp_keep), .clk_out(clk_out), .busy_n(busy_n), .sample_phase(sample_phase),
        .trial_code(trial_code), .output_pins(output_pins), .output_oe(output_oe));

    ////////////////////////////////////////////////////////////////
    // Random source
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next

    // Comparison with counting
    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        checked++;
        if (seen !== exp)
        begin
            failures++;
            $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Verdict and end of run
    task automatic tally_and_finish();
        $display("checked=%0d failures=%0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : tally_and_finish

    // Bounded wait for the busy output to reach a level
    task automatic wait_busy(input logic level, input int bound);
        for (int n = 0; busy_n !== level; n++)
        begin
            if (n > bound)
            begin
                failures++;
                $display("CHECK FAILED t=%0t busy wait timed out", $time);
                timed_out = 1'b1;
                return;
            end
            @(posedge clock);
            #1;
        end
    endtask : wait_busy

    // One conversion, optional restart attempt, then byte and deselected reads
    task automatic convert(input logic [11:0] t, input bit restart);
        if (timed_out)
            return;
        lfsr_r = lfsr_next(lfsr_r);
        target = t;
        exp_q.push_back(t);
        sar_host_model_i.release_bus(130 + int'(lfsr_r[3:0])); // random start phase
        sar_host_model_i.strobe(1'b0, 1'b0);
        wait_busy(1'b0, 12);
        if (timed_out)
            return;
        check(output_oe, 12'hfff);
        check(trial_code, 12'h000);
        check({11'h0, sample_phase}, 12'h000);
        if (restart)
        begin
            repeat (90) @(posedge clock);
            sar_host_model_i.release_bus(2);
            sar_host_model_i.strobe(1'b0, 1'b0);
        end
        wait_busy(1'b1, 300);
        if (timed_out)
            return;
        repeat (4) @(posedge clock);
        sar_host_model_i.strobe(1'b1, 1'b0);
        repeat (5) @(posedge clock);
        #1;
        check(output_pins, {t[11:8], 4'h0, t[11:8]});
        check({11'h0, busy_n}, 12'h001);
        sar_host_model_i.release_bus(1);
        sar_host_model_i.strobe(1'b0, 1'b1);
        repeat (5) @(posedge clock);
        #1;
        check(output_oe, 12'h000);
        check({11'h0, busy_n}, 12'h001);
    endtask : convert

    ////////////////////////////////////////////////////////////////
    // Output watcher: clock output, busy length, results off the queue
    always @(posedge clock)
    begin
        #2;
        stable = (conv_clk_in === last_cc) ? stable + 1 : 0;
        last_cc = conv_clk_in;
        if (rst_done && stable == 4)
            check({11'h0, clk_out}, {11'h0, ~conv_clk_in});
        if (pend > 0)
        begin
            pend--;
            if (pend == 0)
                check(output_pins, (exp_q.size() > 0) ? exp_q.pop_front() : 'x);
        end
        if (busy_n === 1'b0)
            lowc++;
        else if (lowc > 0)
        begin
            check({11'h0, lowc >= 140 && lowc <= 200}, 12'h001);
            check({11'h0, sample_phase}, 12'h001);
            lowc = 0;
            pend = 2;
        end
    end

    // Main sequence
    initial
    begin
        clock = 1'b0;
        rst_n = 1'b0;
        conv_clk_in = 1'b0;
        last_cc = 1'b0;
        target = 12'h000;
        lfsr_r = 32'h52bacdaa;
        repeat (20) @(posedge clock);
        #1;
        rst_n = 1'b1;
        repeat (8) @(posedge clock);
        rst_done = 1'b1;
        convert(12'h000, 1'b0);
        convert(12'hfff, 1'b1);
        for (int i = 0; i < 6; i++)
        begin
            lfsr_r = lfsr_next(lfsr_r);
            convert(lfsr_r[11:0], i[0]);
        end
        tally_and_finish();
    end
endmodule : tb
